// File: verilog/csec_map.vh
// Purpose: Register indices, field positions and constants of the cycle stamp block.
// Assumes: Included by every design file of the block by its bare name.
// Notes:   Definitions only; no logic lives here.
`ifndef CSEC_MAP_VH
`define CSEC_MAP_VH

// ==================================================================
// Model register indices presented on i_mr_idx
`define CSEC_IDX_W           3
`define CSEC_IDX_SETUP_FIRST 3'h0
`define CSEC_IDX_SETUP_SECND 3'h1
`define CSEC_IDX_COUNT_FIRST 3'h2
`define CSEC_IDX_COUNT_SECND 3'h3
`define CSEC_IDX_CYCLE_STAMP 3'h4

// ==================================================================
// Event setup register fields
`define CSEC_CODE_HI  7
`define CSEC_CODE_LO  0
`define CSEC_MASK_HI  15
`define CSEC_MASK_LO  8
`define CSEC_B_LOWPRV 16
`define CSEC_B_RING0  17
`define CSEC_B_EDGE   18
`define CSEC_B_PIN    19
`define CSEC_B_INT    20
`define CSEC_B_GATE   22
`define CSEC_B_FLIP   23
`define CSEC_THR_HI   31
`define CSEC_THR_LO   24
`define CSEC_SETUP_W  32

// ==================================================================
// Widths, reset values and other constants
`define CSEC_STAMP_W    64
`define CSEC_HALF_W     32
`define CSEC_EVCNT_W    40
`define CSEC_EVN_W      8
`define CSEC_SIGN_BIT   31
`define CSEC_PIN_BUSCLK 2
`define CSEC_RING0      2'h0
`define CSEC_ZERO32     32'h0000_0000
`define CSEC_ZERO64     64'h0000_0000_0000_0000
`define CSEC_HOLD_W     8

`endif

// File: verilog/csec_evt_unit.v
// Purpose: One event or duration counter with its filters, wrap and pin logic.
// Assumes: i_events is the number of selected events seen this core clock.
// Notes:   Instantiated once per counter by csec_top.
`include "csec_map.vh"

module csec_evt_unit #(
  parameter CNT_W     = `CSEC_EVCNT_W,
  parameter BUS_RATIO = 1
) (
  input  wire                     i_clk,
  input  wire                     i_reset,
  input  wire [`CSEC_SETUP_W-1:0] i_setup,
  input  wire                     i_gate,
  input  wire [1:0]               i_cpl,
  input  wire [`CSEC_EVN_W-1:0]   i_events,
  input  wire                     i_load,
  input  wire [`CSEC_HALF_W-1:0]  i_load_data,
  output reg  [CNT_W-1:0]         o_count,
  output reg                      o_wrap,
  output reg                      o_pin
);

  // The product is worked out as an integer, then cut to the hold counter on purpose.
  localparam integer            HOLD_I = `CSEC_PIN_BUSCLK * BUS_RATIO;
  localparam [`CSEC_HOLD_W-1:0] HOLD   = HOLD_I[`CSEC_HOLD_W-1:0];

  // ==================================================================
  // Qualification of the event stream
  wire [`CSEC_EVN_W-1:0] thr     = i_setup[`CSEC_THR_HI:`CSEC_THR_LO];
  wire                   thr_on  = (thr != {`CSEC_EVN_W{1'b0}});
  wire                   in_ring0 = (i_cpl == `CSEC_RING0);
  wire                   priv_ok = in_ring0 ? i_setup[`CSEC_B_RING0]
                                            : i_setup[`CSEC_B_LOWPRV];
  wire                   live    = i_gate & priv_ok;
  wire                   cmp     = (i_events >= thr) ^ i_setup[`CSEC_B_FLIP];
  wire                   cond    = thr_on ? cmp : (i_events != {`CSEC_EVN_W{1'b0}});
  reg                    cond_q;
  reg  [`CSEC_HOLD_W-1:0] hold_q;
  reg  [`CSEC_HOLD_W-1:0] hold_d;
  reg  [`CSEC_EVN_W-1:0] inc;
  wire                   rise    = cond & live & ~cond_q;

  // Amount added this cycle; duration mode is a condition source giving one per clock.
  always @*
  begin
    if (!live)
      inc = {`CSEC_EVN_W{1'b0}};
    else if (i_setup[`CSEC_B_EDGE])
      inc = {{(`CSEC_EVN_W-1){1'b0}}, rise};
    else if (thr_on)
      inc = {{(`CSEC_EVN_W-1){1'b0}}, cmp};
    else
      inc = i_events;
  end

  wire [CNT_W:0] sum   = {1'b0, o_count} + {{(CNT_W+1-`CSEC_EVN_W){1'b0}}, inc};
  wire           carry = sum[CNT_W];
  wire           trig  = i_setup[`CSEC_B_PIN] ? carry : (inc != {`CSEC_EVN_W{1'b0}});

  // A new toggle while one is running restarts the hold; pulses may merge.
  always @*
  begin
    if (trig)
      hold_d = HOLD;
    else if (hold_q != {`CSEC_HOLD_W{1'b0}})
      hold_d = hold_q - {{(`CSEC_HOLD_W-1){1'b0}}, 1'b1};
    else
      hold_d = hold_q;
  end

  // Counter, wrap pulse, edge history and monitor pin.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_count <= {CNT_W{1'b0}};
      o_wrap  <= 1'b0;
      o_pin   <= 1'b0;
      cond_q  <= 1'b0;
      hold_q  <= {`CSEC_HOLD_W{1'b0}};
    end
    else
    begin
      cond_q <= cond & live;
      hold_q <= hold_d;
      o_pin  <= (hold_d != {`CSEC_HOLD_W{1'b0}});
      if (i_load)
      begin
        o_count <= {{(CNT_W-`CSEC_HALF_W){i_load_data[`CSEC_SIGN_BIT]}}, i_load_data};
        o_wrap  <= 1'b0;
      end
      else
      begin
        o_count <= sum[CNT_W-1:0];
        o_wrap  <= carry;
      end
    end
  end

endmodule // csec_evt_unit

// File: verilog/csec_top.v
// Purpose: Cycle stamp counter and two event counters with their setup registers.
// Assumes: One access request per clock; requests are synchronous to i_clk.
// Notes:   Every request is answered one clock later on o_ack or o_fault.
//
// What this block does
// - 64-bit cycle stamp advances every core clock
// - Stamp keeps counting while the core halts
// - Reset clears the cycle stamp
// - Stamp write loads low half, zeroes upper
// - Cycle read lock restricts stamp reads to ring0
// - Two independent 40-bit event counters
// - Duration mode counts clocks while condition holds
// - Setup holds event code and unit mask
// - Bit 16 counts at rings one to three
// - Bit 17 counts at ring zero
// - Bit 18 counts only rising condition edges
// - Bit 19 picks pin toggle on wrap or event
// - Pin toggle is active two bus clocks
// - Bit 20 raises interrupt on counter wrap
// - Bit 22 of first setup gates both
// - Bit 23 inverts the threshold comparison
// - Nonzero threshold adds one when met
// - Zero threshold adds full event count
// - Event read lock restricts counter reads to ring0
// - Counter write sign-extends bit 31
// - Model register access only at ring zero
// - Cleared setups stop their counters
`include "csec_map.vh"

module csec_top #(
  parameter CNT_W     = `CSEC_EVCNT_W,
  parameter BUS_RATIO = 1
) (
  input  wire                     i_clk,
  input  wire                     i_reset,
  input  wire [1:0]               i_cpl,
  input  wire                     i_cycle_read_lock,
  input  wire                     i_event_read_lock,
  input  wire                     i_mr_rd,
  input  wire                     i_mr_wr,
  input  wire [`CSEC_IDX_W-1:0]   i_mr_idx,
  input  wire [`CSEC_STAMP_W-1:0] i_mr_wdata,
  input  wire                     i_cycle_read_instr,
  input  wire                     i_event_read_instr,
  input  wire                     i_event_read_sel,
  input  wire [`CSEC_EVN_W-1:0]   i_events_first,
  input  wire [`CSEC_EVN_W-1:0]   i_events_second,
  output reg  [`CSEC_STAMP_W-1:0] o_rd_data,
  output reg                      o_ack,
  output reg                      o_fault,
  output wire [7:0]               o_event_code_first,
  output wire [7:0]               o_unit_mask_first,
  output wire [7:0]               o_event_code_second,
  output wire [7:0]               o_unit_mask_second,
  output wire                     o_monitor_pin_first,
  output wire                     o_monitor_pin_second,
  output reg                      o_overflow_irq
);

  // ==================================================================
  // State
  reg  [`CSEC_STAMP_W-1:0] stamp_q;
  reg  [`CSEC_STAMP_W-1:0] stamp_d;
  reg  [`CSEC_SETUP_W-1:0] setup_first_q;
  reg  [`CSEC_SETUP_W-1:0] setup_second_q;
  wire [CNT_W-1:0]         count_first;
  wire [CNT_W-1:0]         count_second;
  wire                     wrap_first;
  wire                     wrap_second;

  // ==================================================================
  // Request decode and privilege checks
  wire ring0    = (i_cpl == `CSEC_RING0);
  wire mr_any   = i_mr_rd | i_mr_wr;
  wire idx_ok   = (i_mr_idx <= `CSEC_IDX_CYCLE_STAMP);
  wire mr_ok    = mr_any & ring0 & idx_ok;
  wire mr_wr_ok = mr_ok & i_mr_wr;
  wire ev_req   = ~mr_any & i_event_read_instr;
  wire ev_ok    = ev_req & (~i_event_read_lock | ring0);
  wire cy_req   = ~mr_any & ~i_event_read_instr & i_cycle_read_instr;
  wire cy_ok    = cy_req & (~i_cycle_read_lock | ring0);
  wire any_req  = mr_any | ev_req | cy_req;
  wire any_ok   = mr_ok | ev_ok | cy_ok;

  wire wr_setup_first  = mr_wr_ok & (i_mr_idx == `CSEC_IDX_SETUP_FIRST);
  wire wr_setup_second = mr_wr_ok & (i_mr_idx == `CSEC_IDX_SETUP_SECND);
  wire wr_count_first  = mr_wr_ok & (i_mr_idx == `CSEC_IDX_COUNT_FIRST);
  wire wr_count_second = mr_wr_ok & (i_mr_idx == `CSEC_IDX_COUNT_SECND);
  wire wr_stamp        = mr_wr_ok & (i_mr_idx == `CSEC_IDX_CYCLE_STAMP);

  // The gate bit lives only in the first setup register and drives both counters.
  wire gate = setup_first_q[`CSEC_B_GATE];

  // ==================================================================
  // Cycle stamp: counts every clock with no halt input, so halts never stop it.
  always @*
  begin
    if (wr_stamp)
      stamp_d = {`CSEC_ZERO32, i_mr_wdata[`CSEC_HALF_W-1:0]};
    else
      stamp_d = stamp_q + {{(`CSEC_STAMP_W-1){1'b0}}, 1'b1};
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
      stamp_q <= `CSEC_ZERO64;
    else
      stamp_q <= stamp_d;
  end

  // ==================================================================
  // Setup registers. A setup written to all zeros clears both privilege
  // filters, which stops that counter without any extra logic.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      setup_first_q  <= `CSEC_ZERO32;
      setup_second_q <= `CSEC_ZERO32;
    end
    else
    begin
      if (wr_setup_first)
        setup_first_q <= i_mr_wdata[`CSEC_SETUP_W-1:0];
      if (wr_setup_second)
      begin
        setup_second_q              <= i_mr_wdata[`CSEC_SETUP_W-1:0];
        setup_second_q[`CSEC_B_GATE] <= 1'b0;
      end
    end
  end

  // Event code and unit mask steer the external event selection.
  assign o_event_code_first  = setup_first_q[`CSEC_CODE_HI:`CSEC_CODE_LO];
  assign o_unit_mask_first   = setup_first_q[`CSEC_MASK_HI:`CSEC_MASK_LO];
  assign o_event_code_second = setup_second_q[`CSEC_CODE_HI:`CSEC_CODE_LO];
  assign o_unit_mask_second  = setup_second_q[`CSEC_MASK_HI:`CSEC_MASK_LO];

  // ==================================================================
  // Two identical, independent counter units.
  csec_evt_unit #(
    .CNT_W     (CNT_W),
    .BUS_RATIO (BUS_RATIO)
  ) u_first (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_setup     (setup_first_q),
    .i_gate      (gate),
    .i_cpl       (i_cpl),
    .i_events    (i_events_first),
    .i_load      (wr_count_first),
    .i_load_data (i_mr_wdata[`CSEC_HALF_W-1:0]),
    .o_count     (count_first),
    .o_wrap      (wrap_first),
    .o_pin       (o_monitor_pin_first)
  );

  csec_evt_unit #(
    .CNT_W     (CNT_W),
    .BUS_RATIO (BUS_RATIO)
  ) u_second (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_setup     (setup_second_q),
    .i_gate      (gate),
    .i_cpl       (i_cpl),
    .i_events    (i_events_second),
    .i_load      (wr_count_second),
    .i_load_data (i_mr_wdata[`CSEC_HALF_W-1:0]),
    .o_count     (count_second),
    .o_wrap      (wrap_second),
    .o_pin       (o_monitor_pin_second)
  );

  // ==================================================================
  // Overflow interrupt: one pulse per clock in which a counter whose bit 20 is set wraps.
  // The local interrupt controller is expected to latch it.
  always @(posedge i_clk)
  begin
    if (i_reset)
      o_overflow_irq <= 1'b0;
    else
      o_overflow_irq <= (wrap_first & setup_first_q[`CSEC_B_INT]) |
                        (wrap_second & setup_second_q[`CSEC_B_INT]);
  end

  // ==================================================================
  // Read data selection for the three read paths.
  reg [`CSEC_STAMP_W-1:0] rd_d;
  wire [`CSEC_STAMP_W-1:0] cnt1_ext = {{(`CSEC_STAMP_W-CNT_W){1'b0}}, count_first};
  wire [`CSEC_STAMP_W-1:0] cnt2_ext = {{(`CSEC_STAMP_W-CNT_W){1'b0}}, count_second};

  always @*
  begin
    rd_d = `CSEC_ZERO64;
    if (mr_ok & i_mr_rd)
    begin
      case (i_mr_idx)
        `CSEC_IDX_SETUP_FIRST: rd_d = {`CSEC_ZERO32, setup_first_q};
        `CSEC_IDX_SETUP_SECND: rd_d = {`CSEC_ZERO32, setup_second_q};
        `CSEC_IDX_COUNT_FIRST: rd_d = cnt1_ext;
        `CSEC_IDX_COUNT_SECND: rd_d = cnt2_ext;
        `CSEC_IDX_CYCLE_STAMP: rd_d = stamp_q;
        default:               rd_d = `CSEC_ZERO64;
      endcase
    end
    else if (ev_ok)
      rd_d = i_event_read_sel ? cnt2_ext : cnt1_ext;
    else if (cy_ok)
      rd_d = stamp_q;
  end

  // ==================================================================
  // Answer register: exactly one of ack or fault per request, one clock
  // later. Read data holds until the next successful read.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_rd_data <= `CSEC_ZERO64;
      o_ack     <= 1'b0;
      o_fault   <= 1'b0;
    end
    else
    begin
      o_ack   <= any_ok;
      o_fault <= any_req & ~any_ok;
      if (any_ok & ~mr_wr_ok)
        o_rd_data <= rd_d;
    end
  end

endmodule // csec_top

// File: bench/csec_chk.sv
// Purpose: Port-level assertions for csec_top.
// Assumes: One clock domain, synchronous active-high reset, BUS_RATIO of 1.
// Notes:   Attached by the bind after the module.
`include "csec_map.vh"
module csec_chk #(
  parameter CNT_W     = 40,
  parameter BUS_RATIO = 1
) (
  input logic                     i_clk,
  input logic                     i_reset,
  input logic [1:0]               i_cpl,
  input logic                     i_cycle_read_lock,
  input logic                     i_event_read_lock,
  input logic                     i_mr_rd,
  input logic                     i_mr_wr,
  input logic [`CSEC_IDX_W-1:0]   i_mr_idx,
  input logic [`CSEC_STAMP_W-1:0] i_mr_wdata,
  input logic                     i_cycle_read_instr,
  input logic                     i_event_read_instr,
  input logic [`CSEC_STAMP_W-1:0] o_rd_data,
  input logic                     o_ack,
  input logic                     o_fault,
  input logic                     o_monitor_pin_first
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==================================================================
  // Helpers: the write data of two clocks back is kept for loads.
  wire        mop = i_mr_rd | i_mr_wr;
  wire        ok0 = (i_cpl == 2'h0);
  logic [31:0] w1_q, w2_q;
  always @(posedge i_clk)
  begin
    w1_q <= i_mr_wdata[31:0];
    w2_q <= w1_q;
  end
  sequence s_rd(logic [2:0] k); i_mr_rd && !i_mr_wr && ok0 && i_mr_idx == k; endsequence
  sequence s_wr(logic [2:0] k); i_mr_wr && ok0 && i_mr_idx == k; endsequence
  sequence s_cyc; i_cycle_read_instr && !mop && !i_event_read_instr; endsequence
  // ==================================================================
  // Access answers, loads and pin timing.
  AST_MR_ACK: assert property (mop && ok0 && i_mr_idx <= 3'h4 |=> o_ack && !o_fault)
    else $error("model op at ring zero not acknowledged");
  AST_MR_FAULT: assert property (mop && !ok0 |=> o_fault && !o_ack)
    else $error("model op outside ring zero not refused");
  AST_STAMP_STEP: assert property (s_rd(3'h4) ##1 s_rd(3'h4) |=> o_rd_data == $past(o_rd_data) + 64'h1)
    else $error("stamp did not advance by one per clock");
  AST_STAMP_LOAD: assert property (s_wr(3'h4) ##1 s_rd(3'h4) |=> o_rd_data == {32'h0, w2_q})
    else $error("stamp write did not clear upper half");
  AST_COUNT_LOAD: assert property (s_wr(3'h2) ##1 s_rd(3'h2) |=> o_rd_data == {24'h0, {8{w2_q[31]}}, w2_q})
    else $error("counter write not sign extended");
  AST_CYC_LOCK: assert property (s_cyc and (i_cycle_read_lock && !ok0) |=> o_fault)
    else $error("locked stamp read not refused");
  AST_CYC_OPEN: assert property (s_cyc and !i_cycle_read_lock |=> o_ack)
    else $error("unlocked stamp read refused");
  AST_EVT_LOCK: assert property (i_event_read_instr && !mop && i_event_read_lock && !ok0 |=> o_fault)
    else $error("locked counter read not refused");
  AST_PIN_HOLD: assert property ($rose(o_monitor_pin_first) |-> o_monitor_pin_first [*2])
    else $error("monitor pin pulse shorter than two clocks");
endmodule // csec_chk

bind csec_top csec_chk #(.CNT_W(CNT_W), .BUS_RATIO(BUS_RATIO)) chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_cpl(i_cpl), .i_cycle_read_lock(i_cycle_read_lock),
  .i_event_read_lock(i_event_read_lock), .i_mr_rd(i_mr_rd), .i_mr_wr(i_mr_wr),
  .i_mr_idx(i_mr_idx), .i_mr_wdata(i_mr_wdata), .i_cycle_read_instr(i_cycle_read_instr),
  .i_event_read_instr(i_event_read_instr), .o_rd_data(o_rd_data), .o_ack(o_ack),
  .o_fault(o_fault), .o_monitor_pin_first(o_monitor_pin_first));

// File: bench/cycle_stamp_and_event_counters_tb_top.sv
// Purpose: Self-checking bench for csec_top.
// Assumes: BUS_RATIO of 1; every cycle of the main sequence is one op call.
// Notes:   Requests are pipelined, so each op call checks the previous answer.
`include "csec_map.vh"
module cycle_stamp_and_event_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [31:0] setup; logic [7:0] ev; logic [1:0] cpl; logic [39:0] exp; } csec_row_t;
  typedef struct { logic [3:0] rq; logic [2:0] idx; logic [1:0] cpl; logic lk; logic ea; } csec_ref_t;
  localparam logic [3:0] C_RD = 4'h1, C_WR = 4'h2, C_EV = 4'h4, C_CY = 4'h8;
  logic        i_clk, i_reset, i_cycle_read_lock, i_event_read_lock, i_mr_rd, i_mr_wr;
  logic        i_cycle_read_instr, i_event_read_instr, i_event_read_sel;
  logic [1:0]  i_cpl, cpl_v;
  logic [2:0]  i_mr_idx;
  logic [63:0] i_mr_wdata, o_rd_data, pdat;
  logic [7:0]  i_events_first, i_events_second, ev_v, code1, mask1, code2, mask2;
  logic        o_ack, o_fault, pin1, pin2, o_overflow_irq, lock_v, pv, pa, pd;
  int          error_cnt, num_checks, cyc_n, irq_n, pin_n;
  csec_row_t   rows [8] = '{
    '{32'h0043_3412, 8'h01, 2'h0, 40'h4},
    '{32'h0043_3412, 8'h05, 2'h0, 40'h14},
    '{32'h0241_3412, 8'h03, 2'h3, 40'h4},
    '{32'h0443_3412, 8'h03, 2'h0, 40'h0},
    '{32'h0042_3412, 8'h01, 2'h3, 40'h0},
    '{32'h0047_3412, 8'h01, 2'h0, 40'h1},
    '{32'h0003_3412, 8'h01, 2'h0, 40'h0},
    '{32'h04C3_3412, 8'h01, 2'h0, 40'h5}};
  csec_ref_t   refs [8] = '{'{C_RD, 3'h5, 2'h0, 1'b0, 1'b0}, '{C_WR, 3'h0, 2'h3, 1'b0, 1'b0},
    '{C_CY, 3'h0, 2'h3, 1'b1, 1'b0}, '{C_CY, 3'h0, 2'h3, 1'b0, 1'b1},
    '{C_EV, 3'h0, 2'h3, 1'b1, 1'b0}, '{C_EV, 3'h1, 2'h3, 1'b0, 1'b1},
    '{C_EV, 3'h0, 2'h0, 1'b1, 1'b1}, '{C_CY, 3'h0, 2'h0, 1'b1, 1'b1}};

  csec_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_cpl(i_cpl),
    .i_cycle_read_lock(i_cycle_read_lock), .i_event_read_lock(i_event_read_lock),
    .i_mr_rd(i_mr_rd), .i_mr_wr(i_mr_wr), .i_mr_idx(i_mr_idx), .i_mr_wdata(i_mr_wdata),
    .i_cycle_read_instr(i_cycle_read_instr), .i_event_read_instr(i_event_read_instr),
    .i_event_read_sel(i_event_read_sel), .i_events_first(i_events_first),
    .i_events_second(i_events_second), .o_rd_data(o_rd_data), .o_ack(o_ack), .o_fault(o_fault),
    .o_event_code_first(code1), .o_unit_mask_first(mask1), .o_event_code_second(code2),
    .o_unit_mask_second(mask2), .o_monitor_pin_first(pin1), .o_monitor_pin_second(pin2),
    .o_overflow_irq(o_overflow_irq));

  // ==================================================================
  // Clock, plus a cycle count that cuts a hang short and event tallies.
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc_n++;
    if (o_overflow_irq === 1'b1) irq_n++;
    if (pin1 === 1'b1) pin_n++;
    if (pin2 === 1'b1) pin_n++;
    if (cyc_n == 2000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // ==================================================================
  // Comparison, verdict and the pipelined request driver.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin error_cnt++; $display("[ERR] %0t seen %h expected %h", $time, seen, exp); end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Holding each request for exactly one edge avoids it being taken twice.
  task automatic op(input logic [3:0] rq, input logic [2:0] idx, input logic [63:0] wd,
                    input logic ea, input logic ed, input logic [63:0] d);
    @(posedge i_clk);
    {i_cycle_read_instr, i_event_read_instr, i_mr_wr, i_mr_rd} <= rq;
    i_mr_idx <= idx;
    i_event_read_sel <= idx[0];
    i_mr_wdata <= wd;
    i_cpl <= cpl_v;
    i_events_first <= ev_v;
    i_events_second <= ev_v;
    i_cycle_read_lock <= lock_v;
    i_event_read_lock <= lock_v;
    #1;
    if (pv) check({62'h0, o_ack, o_fault}, {62'h0, pa, !pa});
    if (pv && pd) check(o_rd_data, pdat);
    pv = |rq;
    pa = ea;
    pd = ed;
    pdat = d;
  endtask

  // ==================================================================
  // Main sequence: reset, table of counting cases, then awkward cases.
  initial
  begin
    {i_cpl, i_cycle_read_lock, i_event_read_lock, i_mr_rd, i_mr_wr, i_mr_idx} = '0;
    {i_mr_wdata, i_cycle_read_instr, i_event_read_instr, i_event_read_sel} = '0;
    {i_events_first, i_events_second, cpl_v, ev_v, lock_v, pv} = '0;
    i_reset = 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    op(C_RD, 3'h4, 64'h0, 1'b1, 1'b0, 64'h0);
    op(C_WR, 3'h1, 64'h0002_0000, 1'b1, 1'b0, 64'h0);
    check({63'h0, o_rd_data < 64'h8}, 64'h1);
    foreach (rows[i])
    begin
      op(C_WR, 3'h2, 64'h0, 1'b1, 1'b0, 64'h0);
      op(C_WR, 3'h3, 64'h0, 1'b1, 1'b0, 64'h0);
      op(C_WR, 3'h0, {32'h0, rows[i].setup}, 1'b1, 1'b0, 64'h0);
      ev_v = rows[i].ev;
      cpl_v = rows[i].cpl;
      repeat (4) op(4'h0, 3'h0, 64'h0, 1'b0, 1'b0, 64'h0);
      check({48'h0, mask1, code1}, {48'h0, rows[i].setup[15:0]});
      ev_v = 8'h00;
      cpl_v = 2'h0;
      op(C_WR, 3'h0, 64'h0, 1'b1, 1'b0, 64'h0);
      op(C_RD, 3'h2, 64'h0, 1'b1, 1'b1, {24'h0, rows[i].exp});
      op(C_RD, 3'h3, 64'h0, 1'b1, 1'b1,
         (rows[i].setup[22] && rows[i].cpl == 2'h0) ? 64'(rows[i].ev) * 64'h4 : 64'h0);
    end
    // Preload one below wrap, then a single event with pin-on-wrap and interrupt on.
    op(C_WR, 3'h2, 64'hFFFF_FFFF, 1'b1, 1'b0, 64'h0);
    op(C_RD, 3'h2, 64'h0, 1'b1, 1'b1, 64'h0000_00FF_FFFF_FFFF);
    op(C_WR, 3'h0, 64'h005A_0000, 1'b1, 1'b0, 64'h0);
    irq_n = 0;
    pin_n = 0;
    ev_v = 8'h01;
    op(4'h0, 3'h0, 64'h0, 1'b0, 1'b0, 64'h0);
    ev_v = 8'h00;
    repeat (6) op(4'h0, 3'h0, 64'h0, 1'b0, 1'b0, 64'h0);
    check(64'(irq_n), 64'h1);
    check(64'(pin_n), 64'h4);
    op(C_RD, 3'h2, 64'h0, 1'b1, 1'b1, 64'h0);
    op(C_WR, 3'h0, 64'h0, 1'b1, 1'b0, 64'h0);
    op(C_WR, 3'h4, 64'hFFFF_FFFF_1234_5678, 1'b1, 1'b0, 64'h0);
    op(C_RD, 3'h4, 64'h0, 1'b1, 1'b1, 64'h0000_0000_1234_5678);
    op(C_RD, 3'h4, 64'h0, 1'b1, 1'b1, 64'h0000_0000_1234_5679);
    op(C_WR, 3'h1, 64'hFFFF_FFFF, 1'b1, 1'b0, 64'h0);
    op(C_RD, 3'h1, 64'h0, 1'b1, 1'b1, 64'h0000_0000_FFBF_FFFF);
    check({48'h0, mask2, code2}, 64'hFFFF);
    op(C_WR, 3'h1, 64'h0, 1'b1, 1'b0, 64'h0);
    // Refused and permitted reads by index, privilege and lock; the refused write must not land.
    foreach (refs[i])
    begin
      cpl_v = refs[i].cpl;
      lock_v = refs[i].lk;
      op(refs[i].rq, refs[i].idx, 64'hFFFF_FFFF, refs[i].ea, 1'b0, 64'h0);
    end
    cpl_v = 2'h0;
    // The second counter kept the four events of the last row plus the one event of the wrap case.
    op(C_EV, 3'h1, 64'h0, 1'b1, 1'b1, 64'h5);
    op(4'h0, 3'h0, 64'h0, 1'b0, 1'b0, 64'h0);
    check({56'h0, code1}, 64'h0);
    complete_run();
  end
endmodule // cycle_stamp_and_event_counters_tb_top
